//--- design/cix_pkg.sv
// shared constants and types for the instruction timing and xor-accumulator block
package cix_pkg;
  // instruction classes presented by the fetch stage
  typedef enum logic [3:0] {
    CIX_OP_XOR_WITH_ACCUMULATOR   = 4'h0,
    CIX_OP_ANDA   = 4'h1,
    CIX_OP_ORA    = 4'h2,
    CIX_OP_ADDA   = 4'h3,
    CIX_OP_SUBA   = 4'h4,
    CIX_OP_SHIFT  = 4'h5,
    CIX_OP_MOVEM  = 4'h6,
    CIX_OP_RET    = 4'h7,
    CIX_OP_JBIT   = 4'h8,
    CIX_OP_NOP    = 4'h9
  } cix_op_t;

  // execution states, one-hot
  typedef enum logic [3:0] {
    CIX_ST_IDLE = 4'b0001,
    CIX_ST_EXEC = 4'b0010,
    CIX_ST_MEM  = 4'b0100,
    CIX_ST_DONE = 4'b1000
  } cix_state_t;

  // t-state counts
  localparam logic [2:0] CIX_T_REG = 3'h2;
  localparam logic [2:0] CIX_T_IDX = 3'h3;
  localparam logic [2:0] CIX_T_RD4 = 3'h4;
  localparam logic [2:0] CIX_T_JF = 3'h2;
  localparam logic [2:0] CIX_T_JT = 3'h3;

  // flag field positions in the flag vector {n,z,c,v}
  localparam int CIX_F_N = 3;
  localparam int CIX_F_Z = 2;
  localparam int CIX_F_C = 1;
  localparam int CIX_F_V = 0;
  localparam logic [3:0] CIX_FLAGS_RST = 4'h0;
  localparam logic [7:0] CIX_BYTE_RST = 8'h00;
endpackage

//--- design/cix_alu_if.sv
// carrier between the sequencer and the alu leaf
`timescale 1ns/1ps
interface cix_alu_if;
  logic [3:0] op;
  logic [7:0] a;
  logic [7:0] b;
  logic [3:0] flags_old;
  logic [7:0] result;
  logic [3:0] flags_new;
  modport seq (output op, output a, output b, output flags_old,
               input result, input flags_new);
  modport alu (input op, input a, input b, input flags_old,
               output result, output flags_new);
endinterface

//--- design/cix_alu.sv
// combinational alu for accumulator-based operations
`timescale 1ns/1ps
module cix_alu (
  cix_alu_if.alu bus
);
  logic [8:0] sum;
  logic [7:0] res;
  logic c_new;
  logic v_new;
  logic logic_op;

  always_comb begin
    sum = 9'h000;
    res = 8'h00;
    c_new = bus.flags_old[cix_pkg::CIX_F_C];
    v_new = bus.flags_old[cix_pkg::CIX_F_V];
    logic_op = 1'b0;
    unique case (bus.op)
      cix_pkg::CIX_OP_XOR_WITH_ACCUMULATOR: begin
        res = bus.a ^ bus.b;
        logic_op = 1'b1;
      end
      cix_pkg::CIX_OP_ANDA: begin
        res = bus.a & bus.b;
        logic_op = 1'b1;
      end
      cix_pkg::CIX_OP_ORA: begin
        res = bus.a | bus.b;
        logic_op = 1'b1;
      end
      cix_pkg::CIX_OP_ADDA: begin
        sum = {1'b0, bus.a} + {1'b0, bus.b};
        res = sum[7:0];
        c_new = sum[8];
        v_new = (bus.a[7] == bus.b[7]) && (res[7] != bus.a[7]);
      end
      cix_pkg::CIX_OP_SUBA: begin
        sum = {1'b0, bus.a} - {1'b0, bus.b};
        res = sum[7:0];
        c_new = sum[8];
        v_new = (bus.a[7] != bus.b[7]) && (res[7] != bus.a[7]);
      end
      default: begin
        res = bus.a;
      end
    endcase
    bus.result = res;
    // logic ops leave carry and overflow alone
    bus.flags_new = {res[7], (res == 8'h00), c_new, v_new};
    if (logic_op) begin
      bus.flags_new[cix_pkg::CIX_F_C] = bus.flags_old[cix_pkg::CIX_F_C];
      bus.flags_new[cix_pkg::CIX_F_V] = bus.flags_old[cix_pkg::CIX_F_V];
    end
  end
endmodule

//--- design/cix_exec.sv
// instruction execution sequencer with t-state timing and flag handling
`timescale 1ns/1ps
module cix_exec (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // instruction from fetch
  input wire logic issue_in,
  input wire logic [3:0] op_in,
  input wire logic to_mem_in,
  input wire logic [7:0] source_register_in,
  input wire logic restore_flags_option_in,
  input wire logic cond_true_in,
  input wire logic [3:0] stack_flags_in,
  // register state
  input wire logic bank_sel_in,
  input wire logic [7:0] acc0_in,
  input wire logic [7:0] acc1_in,
  input wire logic four_tstate_read_in,
  input wire logic [7:0] mem_rdata_in,
  // results
  output logic busy_out,
  output logic done_out,
  output logic [7:0] result_out,
  output logic reg_we_out,
  output logic mem_we_out,
  output logic mem_re_out,
  output logic jump_out,
  output logic [3:0] flags_out
);
  cix_alu_if alu_bus ();
  cix_alu u_alu (
    .bus(alu_bus)
  );

  ////////////////////////////////////////////////////////////////////
  cix_pkg::cix_state_t state;
  cix_pkg::cix_state_t next_state;
  logic [2:0] tcount;
  logic [2:0] tlen;
  logic [3:0] op;
  logic to_mem;
  logic rflag;
  logic taken;
  logic [7:0] src;
  logic [7:0] acc;
  logic [3:0] stack_flags;

  // decoded length, used at issue
  function automatic logic [2:0] cix_len(input logic [3:0] o, input logic m,
                                         input logic r4, input logic ct);
    logic [2:0] l;
    l = cix_pkg::CIX_T_REG;
    if (o == cix_pkg::CIX_OP_MOVEM) begin
      l = r4 ? cix_pkg::CIX_T_RD4 : cix_pkg::CIX_T_IDX;
    end else if (o == cix_pkg::CIX_OP_JBIT) begin
      l = ct ? cix_pkg::CIX_T_JT : cix_pkg::CIX_T_JF;
    end else if (m) begin
      l = cix_pkg::CIX_T_IDX;
    end
    return l;
  endfunction

  function automatic logic is_alu(input logic [3:0] o);
    return (o <= cix_pkg::CIX_OP_SUBA) || (o == cix_pkg::CIX_OP_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    unique case (state)
      cix_pkg::CIX_ST_IDLE: if (issue_in) next_state = cix_pkg::CIX_ST_EXEC;
      cix_pkg::CIX_ST_EXEC: if (tcount + 3'h2 >= tlen) begin
        next_state = cix_pkg::CIX_ST_DONE;
      end else begin
        next_state = cix_pkg::CIX_ST_MEM;
      end
      cix_pkg::CIX_ST_MEM: if (tcount + 3'h2 >= tlen) next_state = cix_pkg::CIX_ST_DONE;
      cix_pkg::CIX_ST_DONE: next_state = cix_pkg::CIX_ST_IDLE;
      default: next_state = cix_pkg::CIX_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= cix_pkg::CIX_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // t-state counter, cycle of issue is t1
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tcount <= 3'h0;
    end else if (state == cix_pkg::CIX_ST_IDLE) begin
      tcount <= 3'h0;
    end else begin
      tcount <= tcount + 3'h1;
    end
  end

  // latch instruction at issue
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op <= cix_pkg::CIX_OP_NOP;
      to_mem <= 1'b0;
      rflag <= 1'b0;
      taken <= 1'b0;
      src <= cix_pkg::CIX_BYTE_RST;
      acc <= cix_pkg::CIX_BYTE_RST;
      stack_flags <= cix_pkg::CIX_FLAGS_RST;
      tlen <= cix_pkg::CIX_T_REG;
    end else if (state == cix_pkg::CIX_ST_IDLE && issue_in) begin
      op <= op_in;
      to_mem <= to_mem_in;
      rflag <= restore_flags_option_in;
      taken <= cond_true_in;
      src <= source_register_in;
      acc <= bank_sel_in ? acc1_in : acc0_in;
      stack_flags <= stack_flags_in;
      tlen <= cix_len(op_in, to_mem_in, four_tstate_read_in, cond_true_in);
    end
  end

  assign alu_bus.op = op;
  assign alu_bus.a = src;
  assign alu_bus.b = acc;
  assign alu_bus.flags_old = flags_out;

  ////////////////////////////////////////////////////////////////////
  logic finishing;
  assign finishing = (next_state == cix_pkg::CIX_ST_DONE) && (state != cix_pkg::CIX_ST_DONE);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      result_out <= cix_pkg::CIX_BYTE_RST;
      reg_we_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b0;
      jump_out <= 1'b0;
    end else begin
      busy_out <= (next_state != cix_pkg::CIX_ST_IDLE);
      done_out <= finishing;
      reg_we_out <= finishing && ((is_alu(op) && !to_mem) || op == cix_pkg::CIX_OP_MOVEM);
      mem_we_out <= finishing && is_alu(op) && to_mem;
      jump_out <= finishing && op == cix_pkg::CIX_OP_JBIT && taken;
      // reads only: indexed writes and taken jumps also pass the mem state
      mem_re_out <= (op == cix_pkg::CIX_OP_MOVEM) &&
                    ((next_state == cix_pkg::CIX_ST_MEM) || finishing);
      if (finishing) begin
        result_out <= (op == cix_pkg::CIX_OP_MOVEM) ? mem_rdata_in : alu_bus.result;
      end
    end
  end

  // flags
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_out <= cix_pkg::CIX_FLAGS_RST;
    end else if (finishing) begin
      if (op == cix_pkg::CIX_OP_RET) begin
        if (rflag) flags_out <= stack_flags;
      end else if (is_alu(op)) begin
        flags_out <= alu_bus.flags_new;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // measure issue-to-done length
  logic [2:0] seen_len;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_len <= 3'h0;
    end else if (state == cix_pkg::CIX_ST_IDLE) begin
      seen_len <= issue_in ? 3'h1 : 3'h0;
    end else if (!done_out) begin
      seen_len <= seen_len + 3'h1;
    end
  end

  sequence issue_s;
    state == cix_pkg::CIX_ST_IDLE && issue_in;
  endsequence

  reg_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (is_alu(op_in) && !to_mem_in) |-> ##2 done_out)
    else $error("register op length wrong");
  idx_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (is_alu(op_in) && to_mem_in) |-> !done_out[*3] ##1 done_out)
    else $error("indexed write length wrong");
  read_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (op_in == cix_pkg::CIX_OP_MOVEM && four_tstate_read_in)
    |-> !done_out[*4] ##1 done_out)
    else $error("four tstate read length wrong");
  read3_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (op_in == cix_pkg::CIX_OP_MOVEM && !four_tstate_read_in) |-> ##3 done_out)
    else $error("three tstate read length wrong");
  jump_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (op_in == cix_pkg::CIX_OP_JBIT && cond_true_in) |-> ##3 (done_out && jump_out))
    else $error("taken jump length wrong");
  nojump_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (op_in == cix_pkg::CIX_OP_JBIT && !cond_true_in) |-> ##2 (done_out && !jump_out))
    else $error("untaken jump wrong");
  ret_flags_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s ##0 (op_in == cix_pkg::CIX_OP_RET && !restore_flags_option_in)
    |-> ##2 (flags_out == $past(flags_out, 2)))
    else $error("flags changed without restore");
  xor_cv_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    done_out && $past(op) == cix_pkg::CIX_OP_XOR_WITH_ACCUMULATOR
    |-> flags_out[1:0] == $past(flags_out[1:0]))
    else $error("logic op touched carry or overflow");
  xor_res_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    done_out && op == cix_pkg::CIX_OP_XOR_WITH_ACCUMULATOR |-> result_out == (src ^ acc))
    else $error("xor result wrong");
  acc_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    issue_s |=> acc == (($past(bank_sel_in)) ? $past(acc1_in) : $past(acc0_in)))
    else $error("wrong accumulator");
  len_match_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    done_out |-> seen_len == tlen)
    else $error("measured length differs from decoded length");
  rd_strobe_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    mem_re_out |-> op == cix_pkg::CIX_OP_MOVEM)
    else $error("read strobe outside an indexed read");
endmodule

//--- testbench/cix_exec_test.sv
// self-checking bench for the instruction execution sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cix_exec_test;
  ////////////////////////////////////////////////////////////////////////////////
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic issue_in = 1'b0;
  logic to_mem_in = 1'b0;
  logic restore_flags_option_in = 1'b0;
  logic cond_true_in = 1'b0;
  logic bank_sel_in = 1'b0;
  logic four_tstate_read_in = 1'b0;
  logic [3:0] op_in = 4'h9;
  logic [3:0] stack_flags_in = 4'h0;
  logic [7:0] source_register_in = 8'h00;
  logic [7:0] acc0_in = 8'h00;
  logic [7:0] acc1_in = 8'h00;
  logic [7:0] mem_rdata_in = 8'h00;
  wire logic busy_out, done_out, reg_we_out, mem_we_out, mem_re_out, jump_out;
  wire logic [7:0] result_out;
  wire logic [3:0] flags_out;
  int fail_count = 0;
  int checked = 0;
  int seed = 21375;
  logic [3:0] mflags = 4'h0;
  bit fknown = 1'b1;
  always #50 sys_clk_in = ~sys_clk_in;
  cix_exec dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .issue_in(issue_in),
    .op_in(op_in), .to_mem_in(to_mem_in), .source_register_in(source_register_in),
    .restore_flags_option_in(restore_flags_option_in), .cond_true_in(cond_true_in),
    .stack_flags_in(stack_flags_in), .bank_sel_in(bank_sel_in), .acc0_in(acc0_in),
    .acc1_in(acc1_in), .four_tstate_read_in(four_tstate_read_in),
    .mem_rdata_in(mem_rdata_in), .busy_out(busy_out), .done_out(done_out),
    .result_out(result_out), .reg_we_out(reg_we_out), .mem_we_out(mem_we_out),
    .mem_re_out(mem_re_out), .jump_out(jump_out), .flags_out(flags_out));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] exp_len(logic [3:0] op, logic tm, logic r4, logic ct);
    if (op <= 4'h4) return tm ? cix_pkg::CIX_T_IDX : cix_pkg::CIX_T_REG;
    if (op == 4'h6) return r4 ? cix_pkg::CIX_T_RD4 : cix_pkg::CIX_T_IDX;
    if (op == 4'h8) return ct ? cix_pkg::CIX_T_JT : cix_pkg::CIX_T_JF;
    return cix_pkg::CIX_T_REG;
  endfunction
  function automatic logic [8:0] exp_alu(logic [3:0] op, logic [7:0] s, logic [7:0] a);
    case (op)
      4'h0: return {1'b0, s ^ a};
      4'h1: return {1'b0, s & a};
      4'h2: return {1'b0, s | a};
      4'h3: return {1'b0, s} + {1'b0, a};
      4'h4: return {1'b0, s} - {1'b0, a};
      default: return {1'b0, s};
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset(int cycles);
    @(negedge sys_clk_in);
    rst_n_in = 1'b0;
    repeat (cycles) @(negedge sys_clk_in);
    `CHK({busy_out, done_out, reg_we_out, mem_we_out, jump_out}, 5'h00)
    `CHK({result_out, flags_out}, 12'h000)
    rst_n_in = 1'b1;
    mflags = 4'h0;
    fknown = 1'b1;
  endtask
  // issue one instruction; spam keeps issue_in high while busy to probe refusal
  task automatic run(input logic [3:0] op, input logic tm, input logic [7:0] s, input logic rf,
      input logic ct, input logic [3:0] sf, input logic bk, input logic [7:0] a0,
      input logic [7:0] a1, input logic [7:0] md, input logic r4, input bit spam);
    int n;
    logic [7:0] acc;
    logic [8:0] r;
    logic tme;
    tme = tm && (op <= 4'h4);
    op_in = op;
    to_mem_in = tme;
    source_register_in = s;
    restore_flags_option_in = rf;
    cond_true_in = ct;
    stack_flags_in = sf;
    bank_sel_in = bk;
    acc0_in = a0;
    acc1_in = a1;
    mem_rdata_in = md;
    four_tstate_read_in = r4;
    issue_in = 1'b1;
    @(negedge sys_clk_in);
    issue_in = spam;
    n = 1;
    while (done_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    issue_in = 1'b0;
    if (n >= 20) begin
      fail_count++;
      tally_and_finish();
    end
    acc = bk ? a1 : a0;
    r = exp_alu(op, s, acc);
    `CHK(n[2:0], exp_len(op, tme, r4, ct))
    `CHK(jump_out, (op == 4'h8) && ct)
    if (op <= 4'h5) begin
      `CHK(result_out, r[7:0])
      `CHK({reg_we_out, mem_we_out}, {~tme, tme})
    end
    if (op == 4'h6) begin
      `CHK({result_out, reg_we_out, mem_re_out}, {md, 2'b11})
    end
    if (op <= 4'h2) begin
      mflags[cix_pkg::CIX_F_N] = r[7];
      mflags[cix_pkg::CIX_F_Z] = (r[7:0] == 8'h00);
    end
    if (op == 4'h3 || op == 4'h4) begin
      mflags[cix_pkg::CIX_F_N] = r[7];
      mflags[cix_pkg::CIX_F_Z] = (r[7:0] == 8'h00);
      mflags[cix_pkg::CIX_F_C] = r[8];
      mflags[cix_pkg::CIX_F_V] = ((s[7] == acc[7]) == (op == 4'h3)) && (r[7] != s[7]);
    end
    if (op == 4'h5) fknown = 1'b0;
    if (op == 4'h7 && rf) begin
      mflags = sf;
      fknown = 1'b1;
    end
    if (fknown) begin
      `CHK(flags_out, mflags)
    end
    @(negedge sys_clk_in);
    `CHK({busy_out, done_out}, 2'b00)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] op;
    repeat (5) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    // xor to register on bank 0 with zero result, then xor to memory on bank 1
    run(4'h0, 1'b0, 8'h5a, 0, 0, 4'h0, 1'b0, 8'h5a, 8'h0f, 8'h00, 0, 0);
    run(4'h0, 1'b1, 8'h5a, 0, 0, 4'h0, 1'b1, 8'h5a, 8'hf0, 8'h00, 0, 1);
    run(4'h3, 1'b0, 8'h7f, 0, 0, 4'h0, 1'b0, 8'h01, 8'h00, 8'h00, 0, 0);
    run(4'h1, 1'b1, 8'h80, 0, 0, 4'h0, 1'b1, 8'h00, 8'hff, 8'h00, 0, 0);
    run(4'h4, 1'b0, 8'h00, 0, 0, 4'h0, 1'b1, 8'h00, 8'h01, 8'h00, 0, 1);
    run(4'h2, 1'b0, 8'h00, 0, 0, 4'h0, 1'b0, 8'h00, 8'h00, 8'h00, 0, 0);
    $display("test alu corners done");
    run(4'h6, 1'b0, 8'h00, 0, 0, 4'h0, 1'b0, 8'h00, 8'h00, 8'ha5, 0, 0);
    run(4'h6, 1'b0, 8'h00, 0, 0, 4'h0, 1'b0, 8'h00, 8'h00, 8'h3c, 1, 1);
    run(4'h8, 1'b0, 8'h00, 0, 0, 4'h0, 1'b0, 8'h00, 8'h00, 8'h00, 0, 0);
    run(4'h8, 1'b0, 8'h00, 0, 1, 4'h0, 1'b0, 8'h00, 8'h00, 8'h00, 0, 1);
    run(4'h7, 1'b0, 8'h00, 0, 0, 4'hf, 1'b0, 8'h00, 8'h00, 8'h00, 0, 0);
    run(4'h7, 1'b0, 8'h00, 1, 0, 4'ha, 1'b0, 8'h00, 8'h00, 8'h00, 0, 0);
    run(4'h0, 1'b0, 8'h81, 0, 0, 4'h0, 1'b0, 8'h00, 8'h00, 8'h00, 0, 0);
    run(4'h9, 1'b0, 8'h00, 0, 0, 4'h0, 1'b0, 8'h00, 8'h00, 8'h00, 0, 0);
    $display("test timing corners done");
    do_reset(2);
    for (int i = 0; i < 300; i++) begin
      op = 4'($unsigned($random(seed)) % 10);
      run(op, 1'($random(seed)), 8'($random(seed)), 1'($random(seed)), 1'($random(seed)),
        4'($random(seed)), 1'($random(seed)), 8'($random(seed)), 8'($random(seed)),
        8'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    end
    $display("test random mix done");
    tally_and_finish();
  end
endmodule
